/* File: rtl/trace_id_lock_defs.svh */
// offsets, field positions, reset values and codes of the trace unit id and lock registers
`ifndef TRACE_ID_LOCK_DEFS_SVH
`define TRACE_ID_LOCK_DEFS_SVH

// register byte addresses in system space
`define TIL_DEVARCH_ADDR 32'hE0000FBC
`define TIL_LOCK_ACCESS_ADDR 32'hE0000FB0
`define TIL_LOCK_STATUS_ADDR 32'hE0000FB4
`define TIL_DEVTYPE_ADDR 32'hE0000FCC
`define TIL_PID4_ADDR 32'hE0000FD0
`define TIL_PID0_ADDR 32'hE0000FE0
`define TIL_PID1_ADDR 32'hE0000FE4
`define TIL_PID2_ADDR 32'hE0000FE8
`define TIL_PID3_ADDR 32'hE0000FEC

// unlock key
`define TIL_UNLOCK_KEY 32'hC5ACCE55

// lock status field positions
`define TIL_LSR_PRESENT_BIT 0
`define TIL_LSR_LOCKED_BIT 1
`define TIL_LSR_NOT_WORD_BIT 2

// lock state after warm reset
`define TIL_LOCK_RESET 1'h1

// device type codes
`define TIL_MAJOR_MISC 4'h0
`define TIL_MAJOR_TRACE_SRC 4'h3
`define TIL_SUB_OTHER 4'h0
`define TIL_SUB_BUS_STIM 4'h4

// peripheral id fixed fields
`define TIL_JEDEC_USED 1'h1
`define TIL_SIZE_4KB 4'h0

`endif

/* File: rtl/trace_id_lock_pkg.sv */
// types shared by the trace unit id and lock register set
package trace_id_lock_pkg;

  // one register access from the system space
  typedef struct packed {
    logic valid;
    logic write;
    logic priv;
    logic dbg;
    logic [31:0] addr;
    logic [31:0] wdata;
  } access_req_t;

  // answer to an access, one cycle later
  typedef struct packed {
    logic valid;
    logic fault;
    logic [31:0] rdata;
  } access_rsp_t;

  // decoded register selection
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_DEVARCH = 4'h1,
    SEL_LOCK_ACCESS = 4'h2,
    SEL_LOCK_STATUS = 4'h3,
    SEL_DEVTYPE = 4'h4,
    SEL_PID4 = 4'h5,
    SEL_PID0 = 4'h6,
    SEL_PID1 = 4'h7,
    SEL_PID2 = 4'h8,
    SEL_PID3 = 4'h9
  } reg_sel_t;

endpackage : trace_id_lock_pkg

/* File: rtl/trace_unit_id_and_lock_regs.sv */
// identification and software lock register set of the instrumentation trace unit
`timescale 1ns/100ps
`include "trace_id_lock_defs.svh"

module trace_unit_id_and_lock_regs #(
  parameter bit HAS_UNIT = 1'b1,
  parameter bit HAS_MAIN_EXT = 1'b1,
  parameter bit HAS_COMP_ID = 1'b1,
  parameter bit HAS_SW_LOCK = 1'b1,
  parameter bit DEVTYPE_DBG_ONLY = 1'b0,
  // arbitrary value
  parameter logic [11:0] ARCH_PART = 12'h5A5,
  parameter logic [19:0] ARCH_UPPER = 20'h00000,
  parameter logic [3:0] DEV_MAJOR = 4'h3,
  parameter logic [3:0] DEV_SUB = 4'h0,
  // arbitrary value
  parameter logic [11:0] PART_NUMBER = 12'h123,
  // arbitrary value
  parameter logic [6:0] DESIGNER_CODE = 7'h2A,
  // arbitrary value
  parameter logic [3:0] CONT_CODE = 4'h1,
  parameter logic [3:0] REVISION = 4'h0,
  parameter logic [3:0] METAL_FIX = 4'h0,
  parameter logic [3:0] CUST_MOD = 4'h0
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire trace_id_lock_pkg::access_req_t req_in,
  output trace_id_lock_pkg::access_rsp_t rsp_out,
  output logic lock_state_out,
  output logic sw_write_enable_out
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic trace_id_lock_pkg::reg_sel_t decode_addr(input logic [31:0] addr);
    trace_id_lock_pkg::reg_sel_t sel;
    sel = trace_id_lock_pkg::SEL_NONE;
    case (addr)
      `TIL_DEVARCH_ADDR: begin
        sel = trace_id_lock_pkg::SEL_DEVARCH;
      end
      `TIL_LOCK_ACCESS_ADDR: begin
        sel = trace_id_lock_pkg::SEL_LOCK_ACCESS;
      end
      `TIL_LOCK_STATUS_ADDR: begin
        sel = trace_id_lock_pkg::SEL_LOCK_STATUS;
      end
      `TIL_DEVTYPE_ADDR: begin
        sel = trace_id_lock_pkg::SEL_DEVTYPE;
      end
      `TIL_PID4_ADDR: begin
        sel = trace_id_lock_pkg::SEL_PID4;
      end
      `TIL_PID0_ADDR: begin
        sel = trace_id_lock_pkg::SEL_PID0;
      end
      `TIL_PID1_ADDR: begin
        sel = trace_id_lock_pkg::SEL_PID1;
      end
      `TIL_PID2_ADDR: begin
        sel = trace_id_lock_pkg::SEL_PID2;
      end
      `TIL_PID3_ADDR: begin
        sel = trace_id_lock_pkg::SEL_PID3;
      end
      default: begin
        sel = trace_id_lock_pkg::SEL_NONE;
      end
    endcase
    return sel;
  endfunction : decode_addr

  // ------------------------------------------------------------
  // configuration terms
  // ------------------------------------------------------------
  logic unit_on;
  logic id_on;
  logic lock_built;
  logic [3:0] major_eff;
  logic [3:0] sub_eff;

  assign unit_on = HAS_UNIT;
  assign id_on = HAS_UNIT & HAS_COMP_ID;
  assign lock_built = id_on & HAS_SW_LOCK;

  // only the two documented major codes can appear
  assign major_eff = (DEV_MAJOR == `TIL_MAJOR_TRACE_SRC) ? `TIL_MAJOR_TRACE_SRC : `TIL_MAJOR_MISC;

  // sub-type zero only with misc, bus stimulus only with trace source
  always_comb begin
    if (major_eff == `TIL_MAJOR_MISC) begin
      sub_eff = `TIL_SUB_OTHER;
    end else if (DEV_SUB == `TIL_SUB_OTHER) begin
      sub_eff = `TIL_SUB_BUS_STIM;
    end else begin
      sub_eff = DEV_SUB;
    end
  end

  // ------------------------------------------------------------
  // access qualification
  // ------------------------------------------------------------
  trace_id_lock_pkg::reg_sel_t sel;
  logic from_sw;
  logic access_fault;
  logic lock_reg_ok;
  logic lock_write;
  logic devtype_hidden;

  assign sel = decode_addr(req_in.addr);
  assign from_sw = ~req_in.dbg;

  // no main extension: unprivileged software access is refused
  assign access_fault = req_in.valid & ~HAS_MAIN_EXT & ~req_in.priv & from_sw;

  // lock registers answer only to software and only when built
  assign lock_reg_ok = lock_built & from_sw;

  // privileged software write to the lock access register
  assign lock_write = req_in.valid & req_in.write & ~access_fault & lock_reg_ok &
                      req_in.priv & (sel == trace_id_lock_pkg::SEL_LOCK_ACCESS);

  // device type optionally hidden from software, only when there is no main extension
  assign devtype_hidden = ~HAS_MAIN_EXT & DEVTYPE_DBG_ONLY & from_sw;

  // ------------------------------------------------------------
  // software lock state
  // ------------------------------------------------------------
  logic lock_ff;
  logic nxt_lock;

  always_comb begin
    nxt_lock = lock_ff;
    if (lock_write) begin
      // key clears, anything else sets
      nxt_lock = (req_in.wdata != `TIL_UNLOCK_KEY);
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_ff <= `TIL_LOCK_RESET;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  // other trace unit registers gate software writes on this
  assign lock_state_out = lock_built & lock_ff;
  assign sw_write_enable_out = ~(lock_built & lock_ff);

  // ------------------------------------------------------------
  // identification words
  // ------------------------------------------------------------
  logic [31:0] pid_raw [0:4];
  logic [31:0] pid_word [0:4];

  assign pid_raw[0] = {24'h000000, PART_NUMBER[7:0]};
  assign pid_raw[1] = {24'h000000, DESIGNER_CODE[3:0], PART_NUMBER[11:8]};
  assign pid_raw[2] = {24'h000000, REVISION, `TIL_JEDEC_USED, DESIGNER_CODE[6:4]};
  assign pid_raw[3] = {24'h000000, METAL_FIX, CUST_MOD};
  assign pid_raw[4] = {24'h000000, `TIL_SIZE_4KB, CONT_CODE};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pid
      assign pid_word[gi] = id_on ? pid_raw[gi] : 32'h00000000;
    end
  endgenerate

  logic [31:0] devarch_word;
  logic [31:0] devtype_word;
  logic [31:0] lock_status_word;

  assign devarch_word = (id_on & HAS_MAIN_EXT) ? {ARCH_UPPER, ARCH_PART} : 32'h00000000;

  assign devtype_word = (id_on & ~devtype_hidden) ?
                        {24'h000000, sub_eff, major_eff} : 32'h00000000;

  // status word, zero for debugger or absent lock
  always_comb begin
    lock_status_word = 32'h00000000;
    if (lock_reg_ok) begin
      lock_status_word[`TIL_LSR_PRESENT_BIT] = 1'h1;
      lock_status_word[`TIL_LSR_LOCKED_BIT] = lock_ff;
      lock_status_word[`TIL_LSR_NOT_WORD_BIT] = 1'h0;
    end
  end

  // ------------------------------------------------------------
  // read multiplexer
  // ------------------------------------------------------------
  logic [31:0] read_word;

  always_comb begin
    read_word = 32'h00000000;
    unique case (sel)
      trace_id_lock_pkg::SEL_DEVARCH: begin
        read_word = devarch_word;
      end
      trace_id_lock_pkg::SEL_LOCK_ACCESS: begin
        read_word = 32'h00000000;
      end
      trace_id_lock_pkg::SEL_LOCK_STATUS: begin
        read_word = lock_status_word;
      end
      trace_id_lock_pkg::SEL_DEVTYPE: begin
        read_word = devtype_word;
      end
      trace_id_lock_pkg::SEL_PID4: begin
        read_word = pid_word[4];
      end
      trace_id_lock_pkg::SEL_PID0: begin
        read_word = pid_word[0];
      end
      trace_id_lock_pkg::SEL_PID1: begin
        read_word = pid_word[1];
      end
      trace_id_lock_pkg::SEL_PID2: begin
        read_word = pid_word[2];
      end
      trace_id_lock_pkg::SEL_PID3: begin
        read_word = pid_word[3];
      end
      trace_id_lock_pkg::SEL_NONE: begin
        read_word = 32'h00000000;
      end
    endcase
    if (!unit_on || access_fault || req_in.write) begin
      read_word = 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // response registers
  // ------------------------------------------------------------
  logic rsp_valid_ff;
  logic rsp_fault_ff;
  logic [31:0] rsp_rdata_ff;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rsp_valid_ff <= 1'h0;
    end else begin
      rsp_valid_ff <= req_in.valid;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rsp_fault_ff <= 1'h0;
    end else begin
      rsp_fault_ff <= access_fault;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rsp_rdata_ff <= 32'h00000000;
    end else if (req_in.valid) begin
      rsp_rdata_ff <= read_word;
    end else begin
      rsp_rdata_ff <= 32'h00000000;
    end
  end

  assign rsp_out.valid = rsp_valid_ff;
  assign rsp_out.fault = rsp_fault_ff;
  assign rsp_out.rdata = rsp_rdata_ff;

endmodule : trace_unit_id_and_lock_regs

/* File: test/trace_id_lock_assertions.sv */
// port checks for the id and lock register set
`timescale 1ns/100ps
`include "trace_id_lock_defs.svh"
module trace_id_lock_assertions (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire trace_id_lock_pkg::access_req_t req_in,
  input wire trace_id_lock_pkg::access_rsp_t rsp_out,
  input wire logic lock_state_out,
  input wire logic sw_write_enable_out
);
  // ----------
  // checks
  // ----------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic lar_wr;
  logic lsr_rd;
  assign lar_wr = req_in.valid && req_in.write && req_in.addr == `TIL_LOCK_ACCESS_ADDR;
  assign lsr_rd = req_in.valid && !req_in.write && req_in.addr == `TIL_LOCK_STATUS_ADDR;
  a_answer_next_cycle:
    assert property (req_in.valid |=> rsp_out.valid && !rsp_out.fault) else $error("missing answer");
  a_no_stray_answer:
    assert property (!req_in.valid |=> !rsp_out.valid && rsp_out.rdata == 32'h0) else $error("stray answer");
  a_unlock_key:
    assert property (lar_wr && req_in.priv && !req_in.dbg && req_in.wdata == `TIL_UNLOCK_KEY
      |=> !lock_state_out) else $error("key did not unlock");
  a_relock_other:
    assert property (lar_wr && req_in.priv && !req_in.dbg && req_in.wdata != `TIL_UNLOCK_KEY
      |=> lock_state_out) else $error("other value did not lock");
  a_dbg_lock_ignored:
    assert property (lar_wr && req_in.dbg |=> $stable(lock_state_out)) else $error("debugger changed lock");
  a_unpriv_dropped:
    assert property (lar_wr && !req_in.priv |=> $stable(lock_state_out)) else $error("unprivileged lock write");
  a_status_word:
    assert property (lsr_rd && !req_in.dbg |=> rsp_out.rdata == {30'h0, lock_state_out, 1'b1})
      else $error("status word wrong");
  a_dbg_status_zero:
    assert property (lsr_rd && req_in.dbg |=> rsp_out.rdata == 32'h0) else $error("debugger status not zero");
  a_enable_tracks_lock:
    assert property (sw_write_enable_out != lock_state_out) else $error("write enable disagrees with lock");
endmodule : trace_id_lock_assertions

/* File: test/trace_unit_id_and_lock_regs_tb.sv */
// self-checking bench of the id and lock register set
`timescale 1ns/100ps
`include "trace_id_lock_defs.svh"
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module trace_unit_id_and_lock_regs_tb;
  // arbitrary values
  localparam logic [11:0] ARCH_PART = 12'h5A5;
  localparam logic [11:0] PART_NUMBER = 12'h321;
  localparam logic [6:0] DESIGNER_CODE = 7'h35;
  localparam logic [3:0] CONT_CODE = 4'h2;
  localparam logic [31:0] LAR = `TIL_LOCK_ACCESS_ADDR;
  localparam logic [31:0] LSR = `TIL_LOCK_STATUS_ADDR;
  localparam logic [31:0] KEY = `TIL_UNLOCK_KEY;
  logic core_clk_in;
  logic reset_n_in;
  trace_id_lock_pkg::access_req_t req_in;
  trace_id_lock_pkg::access_rsp_t rsp_out;
  logic lock_state_out;
  logic sw_write_enable_out;
  int checks;
  int miscompares;
  logic [31:0] rd;
  logic [31:0] id_addr [7];
  logic [31:0] id_exp [7];
  trace_unit_id_and_lock_regs #(.ARCH_PART(ARCH_PART), .PART_NUMBER(PART_NUMBER),
    .DESIGNER_CODE(DESIGNER_CODE), .CONT_CODE(CONT_CODE)) i_dut (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .req_in(req_in),
    .rsp_out(rsp_out),
    .lock_state_out(lock_state_out),
    .sw_write_enable_out(sw_write_enable_out)
  );
  // ----------
  // tasks
  // ----------
  // full word accesses only, no sub-word transfers
  task automatic acc(input logic wr, input logic pv, input logic dg, input logic [31:0] ad,
                     input logic [31:0] wd, output logic [31:0] rdata);
    @(posedge core_clk_in);
    #1;
    req_in = '{valid: 1'b1, write: wr, priv: pv, dbg: dg, addr: ad, wdata: wd};
    @(posedge core_clk_in);
    #1;
    req_in.valid = 1'b0;
    `CHK("rsp_valid", 1'b1, rsp_out.valid)
    `CHK("rsp_fault", 1'b0, rsp_out.fault)
    rdata = rsp_out.rdata;
  endtask : acc
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // ----------
  // sequence
  // ----------
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
  initial begin
    checks = 0;
    miscompares = 0;
    req_in = '0;
    reset_n_in = 1'b0;
    id_addr = '{`TIL_DEVARCH_ADDR, `TIL_DEVTYPE_ADDR, `TIL_PID0_ADDR, `TIL_PID1_ADDR, `TIL_PID2_ADDR,
      `TIL_PID3_ADDR, `TIL_PID4_ADDR};
    id_exp = '{{20'h0, ARCH_PART}, {24'h0, `TIL_SUB_BUS_STIM, `TIL_MAJOR_TRACE_SRC}, {24'h0, PART_NUMBER[7:0]},
      {24'h0, DESIGNER_CODE[3:0], PART_NUMBER[11:8]}, {24'h0, 4'h0, 1'b1, DESIGNER_CODE[6:4]}, 32'h0,
      {24'h0, 4'h0, CONT_CODE}};
    repeat (16) @(posedge core_clk_in);
    #1;
    reset_n_in = 1'b1;
    `CHK("lock_after_reset", 1'b1, lock_state_out)
    `CHK("wr_en_after_reset", 1'b0, sw_write_enable_out)
    for (int i = 0; i < 7; i++) begin
      acc(1'b0, 1'b1, 1'b0, id_addr[i], 32'h0, rd);
      `CHK("id_word", id_exp[i], rd)
    end
    acc(1'b1, 1'b1, 1'b0, `TIL_DEVTYPE_ADDR, 32'hFFFFFFFF, rd);
    acc(1'b0, 1'b0, 1'b1, `TIL_DEVTYPE_ADDR, 32'h0, rd);
    `CHK("devtype_fixed", id_exp[1], rd)
    acc(1'b0, 1'b1, 1'b0, LSR, 32'h0, rd);
    `CHK("status_locked", 32'h3, rd)
    acc(1'b0, 1'b1, 1'b1, LSR, 32'h0, rd);
    `CHK("status_dbg", 32'h0, rd)
    acc(1'b1, 1'b0, 1'b0, LAR, KEY, rd);
    `CHK("unpriv_unlock", 1'b1, lock_state_out)
    acc(1'b1, 1'b1, 1'b1, LAR, KEY, rd);
    `CHK("dbg_unlock", 1'b1, lock_state_out)
    acc(1'b1, 1'b1, 1'b0, LAR, KEY, rd);
    `CHK("unlocked", 1'b0, lock_state_out)
    `CHK("wr_en_open", 1'b1, sw_write_enable_out)
    acc(1'b0, 1'b0, 1'b0, LSR, 32'h0, rd);
    `CHK("status_open", 32'h1, rd)
    acc(1'b1, 1'b1, 1'b1, LAR, 32'h0, rd);
    `CHK("dbg_relock", 1'b0, lock_state_out)
    acc(1'b0, 1'b1, 1'b1, LAR, 32'h0, rd);
    `CHK("dbg_lar_read", 32'h0, rd)
    acc(1'b1, 1'b1, 1'b0, LAR, KEY ^ 32'h1, rd);
    `CHK("relocked", 1'b1, lock_state_out)
    acc(1'b0, 1'b1, 1'b0, 32'hE0000FC0, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    acc(1'b1, 1'b1, 1'b0, LAR, KEY, rd);
    @(posedge core_clk_in);
    #1;
    reset_n_in = 1'b0;
    #1;
    `CHK("lock_mid_reset", 1'b1, lock_state_out)
    repeat (16) @(posedge core_clk_in);
    #1;
    reset_n_in = 1'b1;
    acc(1'b0, 1'b1, 1'b0, LSR, 32'h0, rd);
    `CHK("status_after_reset", 32'h3, rd)
    final_report();
  end
endmodule : trace_unit_id_and_lock_regs_tb
bind trace_unit_id_and_lock_regs trace_id_lock_assertions i_chk (
  .core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in),
  .req_in(req_in),
  .rsp_out(rsp_out),
  .lock_state_out(lock_state_out),
  .sw_write_enable_out(sw_write_enable_out)
);
